// ---- inc/usb_ep_map.vh ----
// register map, field positions and codes of the usb endpoint engine
`ifndef USB_EP_MAP_VH
`define USB_EP_MAP_VH
`define R_CSR0    4'h0
`define R_IRQIN   4'h1
`define R_IRQOUT  4'h2
`define R_TXMAX   4'h3
`define R_TXCL    4'h4
`define R_TXCH    4'h5
`define R_RXMAX   4'h6
`define R_RXCL    4'h7
`define R_RXCH    4'h8
`define R_RXCNT   4'h9
`define R_TXFIFO  4'ha
`define R_RXFIFO  4'hb
`define C0_IPR    1
`define C0_SENT   2
`define C0_DEND   3
`define C0_SEND   5
`define C0_CLROPR 6
`define C0_CLRSUP 7
`define TX_RDY    0
`define TX_UNR    2
`define TX_FLUSH  3
`define TX_SEND   4
`define TX_SENT   5
`define TX_CLRTOG 6
`define TX_INC    7
`define RX_OPR    0
`define RX_OVR    2
`define RX_DERR   3
`define RX_FLUSH  4
`define RX_SEND   5
`define RX_SENT   6
`define RX_CLRTOG 7
`define RH_INCRX  0
`define RH_PIDE   2
`define XH_DBD    1
`define XH_FRC    3
`define XH_ACLR   7
`define TOK_SETUP 2'h0
`define TOK_OUT   2'h1
`define TOK_IN    2'h2
`define TOK_PING  2'h3
`define HS_ACK    2'h0
`define HS_NAK    2'h1
`define HS_STALL  2'h2
`define HS_NYET   2'h3
`define T_ISO     2'h1
`define T_BULK    2'h2
`define T_INT     2'h3
`define PID_D0    2'h0
`define PID_D1    2'h1
`define PID_MDATA 2'h3
`define SETUP_LEN 14'h0008
`define FIFO_RST  14'h0200
`endif

// ---- src/usb_device_endpoint_engine.v ----
// endpoint 0 control logic plus one data endpoint pair of a usb device
// ----
// Behaviour
// - ep0 takes 8-byte setup command
// - ep0 OUT after dataend on write: stall
// - ep0 IN after dataend on read: stall
// - ep0 OUT packet above max size: stall
// - nonzero DATA1 in read status: stall
// - early status or new setup: setupend
// - IN double buffer when fits half fifo
// - OUT double buffer when fits half fifo
// - autoset arms IN after full packet load
// - autoclear releases OUT after full unload
// - bulk IN block split into max packets
// - bulk OUT packets combined into one
// - IN sendstall: stall next IN, flag
// - OUT sendstall: stall next packet, flag
// - forced toggle treats interrupt IN delivered
// - interrupt OUT never NYET, no ping
// - iso IN empty: underrun, zero length
// - hb iso IN short: flag, flush head
// - iso OUT into full fifo: overrun
// - iso OUT crc error: store, flag
// - hb iso OUT short: incomplete flag
// - hb iso OUT wrong pid: pid error
// ----
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "usb_ep_map.vh"

module usb_device_endpoint_engine #(
  parameter [3:0]  EPN     = 4'h1,
  parameter [13:0] TX_FIFO = `FIFO_RST,
  parameter [13:0] RX_FIFO = `FIFO_RST
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire        tok_valid,
  input  wire [1:0]  tok_type,
  input  wire [3:0]  tok_ep,
  input  wire        rx_done,
  input  wire [10:0] rx_len,
  input  wire        rx_crc_err,
  input  wire [1:0]  rx_pid,
  input  wire        setup_dir_in,
  input  wire        host_ack,
  input  wire        sof,
  output reg         hs_valid,
  output reg  [1:0]  hs_code,
  output reg         tx_start,
  output reg  [10:0] tx_len,
  output reg  [1:0]  tx_pid
);

  localparam [2:0] P_IDLE = 3'h1;
  localparam [2:0] P_DATA = 3'h2;
  localparam [2:0] P_STAT = 3'h4;

  reg [2:0]  ph;
  reg        c_dir, c_opr, c_ipr, c_sent, c_dend, c_sup, c_send, c0w;
  reg [6:0]  c_len;
  reg [11:0] irq_in, irq_out;
  reg [1:0]  ltok;
  reg [3:0]  lep;
  reg [12:0] tmax, rmax;
  reg        t_dbd, t_frc, t_aset, t_send, t_sent, t_unr;
  reg        tx_incomplete_split_flag;
  reg [1:0]  t_type, r_type;
  reg [1:0]  tq, rq, rcnt;
  reg [13:0] tl0, tl1, tload, rl0, rl1, racc, runl;
  reg        tpart, twait, ttog;
  reg        r_dbd, r_aclr, r_send, r_sent, r_ovr, r_derr, r_incrx, r_pide;
  reg [15:0] rv;

  // ----
  // derived sizes and queue decisions
  // ----
  wire [13:0] tsize = {3'h0, tmax[10:0]};
  wire [13:0] ttot  = tsize * ({12'h0, tmax[12:11]} + 14'h0001);
  wire [1:0]  tcap  = (!t_dbd && {ttot[12:0], 1'b0} <= TX_FIFO) ? 2'h2 : 2'h1;
  wire [13:0] tchk  = (tl0 < tsize) ? tl0 : tsize;
  wire        tiso  = t_type == `T_ISO;
  wire        t_in  = tok_valid && tok_type == `TOK_IN && tok_ep == EPN;
  wire        t_go  = t_in && !t_send && tq != 2'h0;
  // forced toggle: no ack wait, the packet counts as delivered
  wire        t_now = tiso || (t_type == `T_INT && t_frc);
  wire        t_adv = (t_go && t_now) || (host_ack && twait);
  wire        t_sfl = sof && tiso && tpart;
  wire        t_wcl = wr && addr == `R_TXCL;
  wire        t_fl  = t_wcl && wdata[`TX_FLUSH] && tq != 2'h0;
  wire        t_pop = (t_adv && tl0 == tchk) || t_sfl || t_fl;
  wire        t_fw  = wr && addr == `R_TXFIFO;
  wire        t_as  = t_aset && t_fw && tload + 14'h0001 == ttot;
  wire        t_push = (t_as || (t_wcl && wdata[`TX_RDY])) && (tq < tcap || t_pop);
  wire [13:0] tpl   = t_as ? tload + 14'h0001 : tload;

  wire [13:0] rsize = {3'h0, rmax[10:0]};
  wire [13:0] rtot  = rsize * ({12'h0, rmax[12:11]} + 14'h0001);
  wire [1:0]  rcap  = (!r_dbd && {rtot[12:0], 1'b0} <= RX_FIFO) ? 2'h2 : 2'h1;
  wire [1:0]  rm    = rmax[12:11];
  wire        riso  = r_type == `T_ISO;
  wire        rbulk = r_type == `T_BULK;
  wire [13:0] rlen  = {3'h0, rx_len};
  wire [13:0] racn  = racc + rlen;
  wire        r_pkt = rx_done && lep == EPN && ltok == `TOK_OUT;
  wire        r_room = rq < rcap;
  // short packet or full block closes a combined transfer
  wire        r_end = !rbulk || rlen < rsize || racn >= rtot;
  wire        r_ok  = !r_send && r_room && (riso || !rx_crc_err);
  wire        r_push = r_pkt && r_ok && r_end;
  wire        r_unl = rd && addr == `R_RXFIFO && rq != 2'h0;
  wire        r_ac  = r_aclr && r_unl && runl + 14'h0001 == rtot;
  wire        r_wcl = wr && addr == `R_RXCL && rq != 2'h0;
  wire        r_pop = r_ac || (r_wcl && (!wdata[`RX_OPR] || wdata[`RX_FLUSH]));
  wire [1:0]  rexp  = (rcnt == rm) ? rm : `PID_MDATA;

  // ----
  // packet queues, at most two entries each
  // ----
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tq <= 2'h0;
      tl0 <= 14'h0;
      tl1 <= 14'h0;
      rq <= 2'h0;
      rl0 <= 14'h0;
      rl1 <= 14'h0;
    end else begin
      if (t_adv && !t_pop)
        tl0 <= tl0 - tchk;
      case ({t_push, t_pop})
        2'b10: begin
          if (tq == 2'h0)
            tl0 <= tpl;
          else
            tl1 <= tpl;
          tq <= tq + 2'h1;
        end
        2'b01: begin
          tl0 <= tl1;
          tq <= tq - 2'h1;
        end
        2'b11: begin
          tl0 <= (tq == 2'h1) ? tpl : tl1;
          tl1 <= tpl;
        end
        default: ;
      endcase
      case ({r_push, r_pop})
        2'b10: begin
          if (rq == 2'h0)
            rl0 <= racn;
          else
            rl1 <= racn;
          rq <= rq + 2'h1;
        end
        2'b01: begin
          rl0 <= rl1;
          rq <= rq - 2'h1;
        end
        2'b11: begin
          rl0 <= (rq == 2'h1) ? racn : rl1;
          rl1 <= racn;
        end
        default: ;
      endcase
    end
  end

  // ----
  // handshake and transmit helpers
  // ----
  task hs;
    input [1:0] c;
    begin
      hs_valid <= 1'b1;
      hs_code <= c;
    end
  endtask

  task snd;
    input [10:0] n;
    input [1:0]  p;
    begin
      tx_start <= 1'b1;
      tx_len <= n;
      tx_pid <= p;
    end
  endtask

  task st0;
    begin
      hs(`HS_STALL);
      c_sent <= 1'b1;
      c_dend <= 1'b0;
      irq_in[0] <= 1'b1;
      ph <= P_IDLE;
    end
  endtask

  // ----
  // registers and bus events; events come last so an event beats a register write in the same cycle
  // ----
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= P_IDLE;
      {c_dir, c_opr, c_ipr, c_sent, c_dend, c_sup, c_send, c0w} <= 8'h00;
      c_len <= 7'h00;
      irq_in <= 12'h000;
      irq_out <= 12'h000;
      ltok <= `TOK_SETUP;
      lep <= 4'h0;
      tmax <= 13'h0000;
      rmax <= 13'h0000;
      {t_dbd, t_frc, t_aset, t_send, t_sent, t_unr} <= 6'h00;
      tx_incomplete_split_flag <= 1'b0;
      t_type <= `T_BULK;
      r_type <= `T_BULK;
      rcnt <= 2'h0;
      tload <= 14'h0;
      racc <= 14'h0;
      runl <= 14'h0;
      {tpart, twait, ttog} <= 3'h0;
      {r_dbd, r_aclr, r_send, r_sent, r_ovr, r_derr, r_incrx, r_pide} <= 8'h00;
      hs_valid <= 1'b0;
      hs_code <= `HS_ACK;
      tx_start <= 1'b0;
      tx_len <= 11'h000;
      tx_pid <= `PID_D0;
    end else begin
      hs_valid <= 1'b0;
      tx_start <= 1'b0;
      if (tok_valid) begin
        ltok <= tok_type;
        lep <= tok_ep;
        twait <= 1'b0;
      end
      if (wr) begin
        case (addr)
          `R_CSR0: begin
            c_send <= wdata[`C0_SEND];
            if (wdata[`C0_DEND])
              c_dend <= 1'b1;
            if (wdata[`C0_IPR]) begin
              c_ipr <= 1'b1;
              c_len <= wdata[14:8];
            end
            if (wdata[`C0_CLROPR])
              c_opr <= 1'b0;
            if (wdata[`C0_CLRSUP])
              c_sup <= 1'b0;
            if (!wdata[`C0_SENT])
              c_sent <= 1'b0;
          end
          `R_IRQIN: irq_in <= irq_in & ~wdata[11:0];
          `R_IRQOUT: irq_out <= irq_out & ~wdata[11:0];
          `R_TXMAX: tmax <= wdata[12:0];
          `R_TXCL: begin
            t_send <= wdata[`TX_SEND];
            if (!wdata[`TX_UNR])
              t_unr <= 1'b0;
            if (!wdata[`TX_SENT])
              t_sent <= 1'b0;
            if (!wdata[`TX_INC])
              tx_incomplete_split_flag <= 1'b0;
            if (wdata[`TX_CLRTOG])
              ttog <= 1'b0;
          end
          `R_TXCH: begin
            t_dbd <= wdata[`XH_DBD];
            t_frc <= wdata[`XH_FRC];
            t_type <= wdata[5:4];
            t_aset <= wdata[`XH_ACLR];
          end
          `R_RXMAX: rmax <= wdata[12:0];
          `R_RXCL: begin
            r_send <= wdata[`RX_SEND];
            if (!wdata[`RX_OVR])
              r_ovr <= 1'b0;
            if (!wdata[`RX_DERR])
              r_derr <= 1'b0;
            if (!wdata[`RX_SENT])
              r_sent <= 1'b0;
          end
          `R_RXCH: begin
            r_dbd <= wdata[`XH_DBD];
            r_type <= wdata[5:4];
            r_aclr <= wdata[`XH_ACLR];
            if (!wdata[`RH_INCRX])
              r_incrx <= 1'b0;
            if (!wdata[`RH_PIDE])
              r_pide <= 1'b0;
          end
          default: ;
        endcase
      end
      // fifo byte counters; the data path itself sits outside
      if (t_push)
        tload <= 14'h0;
      else if (t_fw)
        tload <= tload + 14'h0001;
      if (r_pop)
        runl <= 14'h0;
      else if (r_unl)
        runl <= runl + 14'h0001;

      // ----
      // endpoint 0
      // ----
      if (rx_done && lep == 4'h0 && ltok == `TOK_SETUP) begin
        if (rlen == `SETUP_LEN) begin
          if (!ph[0])
            c_sup <= 1'b1;
          c_opr <= 1'b1;
          c_dir <= setup_dir_in;
          c_dend <= 1'b0;
          c_ipr <= 1'b0;
          c0w <= 1'b0;
          ph <= P_DATA;
          hs(`HS_ACK);
          irq_in[0] <= 1'b1;
        end
      end else if (tok_valid && tok_type == `TOK_IN && tok_ep == 4'h0) begin
        case (ph)
          P_DATA: begin
            if (c_send)
              st0;
            else if (c_dir) begin
              if (c_ipr) begin
                snd({4'h0, c_len}, `PID_D1);
                c0w <= 1'b1;
              end else if (c_dend)
                st0;
              else
                hs(`HS_NAK);
            end else if (c_dend) begin
              snd(11'h000, `PID_D1);
              c0w <= 1'b1;
              ph <= P_STAT;
            end else begin
              c_sup <= 1'b1;
              irq_in[0] <= 1'b1;
              ph <= P_IDLE;
              hs(`HS_NAK);
            end
          end
          default: hs(`HS_NAK);
        endcase
      end else if (rx_done && lep == 4'h0 && ltok == `TOK_OUT) begin
        case (ph)
          P_DATA: begin
            if (c_send)
              st0;
            else if (c_dir) begin
              if (!c_dend) begin
                c_sup <= 1'b1;
                irq_in[0] <= 1'b1;
                ph <= P_IDLE;
                hs(`HS_ACK);
              end else if (rx_pid == `PID_D1 && rlen != 14'h0)
                st0;
              else begin
                c_dend <= 1'b0;
                ph <= P_IDLE;
                irq_in[0] <= 1'b1;
                hs(`HS_ACK);
              end
            end else if (c_dend)
              st0;
            else if (rlen > rsize)
              st0;
            else if (c_opr)
              hs(`HS_NAK);
            else begin
              c_opr <= 1'b1;
              irq_in[0] <= 1'b1;
              hs(`HS_ACK);
            end
          end
          default: st0;
        endcase
      end else if (host_ack && c0w && lep == 4'h0) begin
        c0w <= 1'b0;
        irq_in[0] <= 1'b1;
        if (ph[2]) begin
          ph <= P_IDLE;
          c_dend <= 1'b0;
        end else
          c_ipr <= 1'b0;
      end

      // ----
      // data endpoint, IN direction
      // ----
      if (t_in) begin
        if (t_send) begin
          hs(`HS_STALL);
          t_sent <= 1'b1;
          irq_in[EPN] <= 1'b1;
        end else if (tq != 2'h0) begin
          snd(tchk[10:0], tiso ? `PID_D0 : {1'b0, ttog});
          if (!t_now)
            twait <= 1'b1;
        end else if (tiso) begin
          t_unr <= 1'b1;
          snd(11'h000, `PID_D0);
        end else
          hs(`HS_NAK);
      end
      if (t_adv)
        ttog <= ~ttog;
      if (host_ack && twait)
        twait <= 1'b0;
      if (t_pop)
        tpart <= 1'b0;
      else if (t_adv)
        tpart <= 1'b1;
      if (t_sfl)
        tx_incomplete_split_flag <= 1'b1;
      if (t_adv && t_pop)
        irq_in[EPN] <= 1'b1;

      // ----
      // data endpoint, OUT direction
      // ----
      // interrupt endpoints ignore ping; the NYET path below is taken by bulk endpoints only
      if (tok_valid && tok_type == `TOK_PING && tok_ep == EPN && r_type != `T_INT)
        hs(r_room ? `HS_ACK : `HS_NAK);
      if (r_pkt) begin
        if (r_send) begin
          hs(`HS_STALL);
          r_sent <= 1'b1;
          irq_out[EPN] <= 1'b1;
        end else if (riso) begin
          if (rcnt != 2'h3)
            rcnt <= rcnt + 2'h1;
          if (rm != 2'h0 && rx_pid != rexp)
            r_pide <= 1'b1;
          if (!r_room)
            r_ovr <= 1'b1;
          else begin
            if (rx_crc_err) r_derr <= 1'b1;
            irq_out[EPN] <= 1'b1;
          end
        end else if (!rx_crc_err) begin
          if (!r_room)
            hs(`HS_NAK);
          else begin
            if (rbulk && r_end && rq + 2'h1 == rcap)
              hs(`HS_NYET);
            else
              hs(`HS_ACK);
            racc <= r_end ? 14'h0 : racn;
            if (r_end)
              irq_out[EPN] <= 1'b1;
          end
        end
      end
      if (sof) begin
        if (riso && rm != 2'h0 && rcnt != 2'h0 && rcnt <= rm)
          r_incrx <= 1'b1;
        rcnt <= 2'h0;
      end
    end
  end

  // ----
  // read port, data one cycle after the strobe
  // ----
  always @* begin
    case (addr)
      `R_CSR0:   rv = {1'b0, c_len, 2'h0, c_send, c_sup, c_dend, c_sent, c_ipr, c_opr};
      `R_IRQIN:  rv = {4'h0, irq_in};
      `R_IRQOUT: rv = {4'h0, irq_out};
      `R_TXMAX:  rv = {3'h0, tmax};
      `R_TXCL:   rv = {8'h00, tx_incomplete_split_flag, 1'b0, t_sent, t_send, 1'b0,
                       t_unr, tq != 2'h0, tq == tcap};
      `R_TXCH:   rv = {8'h00, t_aset, 1'b0, t_type, t_frc, 1'b0, t_dbd, 1'b0};
      `R_RXMAX:  rv = {3'h0, rmax};
      `R_RXCL:   rv = {8'h00, 1'b0, r_sent, r_send, 1'b0, r_derr, r_ovr,
                       rq == rcap, rq != 2'h0};
      `R_RXCH:   rv = {8'h00, r_aclr, 1'b0, r_type, 1'b0, r_pide, r_dbd, r_incrx};
      `R_RXCNT:  rv = {2'h0, (rq != 2'h0) ? rl0 : 14'h0};
      default:   rv = 16'h0000;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= rv;
    else
      rdata <= 16'h0000;
  end

endmodule // usb_device_endpoint_engine

// ---- tb/usb_ep_engine_monitor.sv ----
// concurrent checks on the endpoint engine ports
`include "usb_ep_map.vh"
module usb_ep_engine_monitor #(
  parameter [3:0]  EPN     = 4'h1
) (
  input logic        mclk,
  input logic        rst_n,
  input logic [3:0]  addr,
  input logic [15:0] wdata,
  input logic        wr,
  input logic        rd,
  input logic [15:0] rdata,
  input logic        tok_valid,
  input logic [1:0]  tok_type,
  input logic [3:0]  tok_ep,
  input logic        rx_done,
  input logic [10:0] rx_len,
  input logic        rx_crc_err,
  input logic        hs_valid,
  input logic [1:0]  hs_code,
  input logic        tx_start,
  input logic [10:0] tx_len
);
  // ----
  // shadow of firmware settings
  // ----
  logic [10:0] txmax;
  logic [1:0]  rxtype;
  logic [1:0]  ltype;
  logic [3:0]  lep;
  logic        txstall, rxstall;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txmax   <= 11'h000;
      rxtype  <= `T_BULK;
      ltype   <= 2'h0;
      lep     <= 4'h0;
      txstall <= 1'b0;
      rxstall <= 1'b0;
    end else begin
      if (wr && addr == `R_TXMAX) txmax <= wdata[10:0];
      if (wr && addr == `R_RXCH) rxtype <= wdata[5:4];
      if (wr && addr == `R_TXCL) txstall <= wdata[4];
      if (wr && addr == `R_RXCL) rxstall <= wdata[5];
      if (tok_valid) ltype <= tok_type;
      if (tok_valid) lep <= tok_ep;
    end
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  hs_cause_a: assert property (hs_valid |-> $past(tok_valid || rx_done))
    else $error("handshake without cause");
  tx_cause_a: assert property (tx_start |-> $past(tok_valid && tok_type == `TOK_IN))
    else $error("data packet without in token");
  setup_ack_a: assert property (rx_done && ltype == `TOK_SETUP && lep == 4'h0
    && rx_len == 11'h008 |=> hs_valid && hs_code == `HS_ACK)
    else $error("setup not acked");
  in_stall_a: assert property (tok_valid && tok_type == `TOK_IN && tok_ep == EPN
    && txstall |=> hs_valid && hs_code == `HS_STALL)
    else $error("in stall not sent");
  out_stall_a: assert property (rx_done && ltype == `TOK_OUT && lep == EPN
    && rxstall && !rx_crc_err |=> hs_valid && hs_code == `HS_STALL)
    else $error("out stall not sent");
  no_nyet_a: assert property (hs_valid && rxtype == `T_INT |-> hs_code != `HS_NYET)
    else $error("nyet on interrupt endpoint");
  ping_quiet_a: assert property (tok_valid && tok_type == `TOK_PING && tok_ep == EPN
    && rxtype == `T_INT |=> !hs_valid)
    else $error("ping answered on interrupt endpoint");
  split_len_a: assert property (tx_start && $past(tok_ep) == EPN |-> tx_len <= txmax)
    else $error("packet above max size");
  iso_quiet_a: assert property (rx_done && ltype == `TOK_OUT && lep == EPN
    && rxtype == `T_ISO && !rxstall |=> !hs_valid)
    else $error("handshake on iso out");
endmodule // usb_ep_engine_monitor
bind usb_device_endpoint_engine usb_ep_engine_monitor #(.EPN(EPN)) i_mon (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tok_valid(tok_valid), .tok_type(tok_type), .tok_ep(tok_ep),
  .rx_done(rx_done), .rx_len(rx_len), .rx_crc_err(rx_crc_err), .hs_valid(hs_valid),
  .hs_code(hs_code), .tx_start(tx_start), .tx_len(tx_len));

// ---- tb/usb_host_model.sv ----
// host side model: tokens, data packets, acks
module usb_host_model (
  input  logic        mclk,
  output logic        tok_valid,
  output logic [1:0]  tok_type,
  output logic [3:0]  tok_ep,
  output logic        rx_done,
  output logic [10:0] rx_len,
  output logic        rx_crc_err,
  output logic [1:0]  rx_pid,
  output logic        setup_dir_in,
  output logic        host_ack,
  output logic        sof,
  input  logic        hs_valid,
  input  logic [1:0]  hs_code,
  input  logic        tx_start,
  input  logic [10:0] tx_len,
  input  logic [1:0]  tx_pid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        got_hs = 1'b0;
  logic        got_tx = 1'b0;
  logic [1:0]  hs_seen = 2'h0;
  logic [1:0]  pid_seen = 2'h0;
  logic [10:0] len_seen = 11'h000;
  initial begin
    {tok_valid, tok_type, tok_ep, rx_done, rx_len} = '0;
    {rx_crc_err, rx_pid, setup_dir_in, host_ack, sof} = '0;
  end
  // answers stand one cycle only, so look right after the taking edge
  task automatic look();
    #1;
    if (hs_valid === 1'b1) begin
      got_hs = 1'b1;
      hs_seen = hs_code;
    end
    if (tx_start === 1'b1) begin
      got_tx = 1'b1;
      len_seen = tx_len;
      pid_seen = tx_pid;
    end
  endtask
  // released qualifiers flip so stale values never pass
  task automatic token(input logic [1:0] t, input logic [3:0] ep);
    got_hs = 1'b0;
    got_tx = 1'b0;
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_type <= t;
    tok_ep <= ep;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_type <= ~t;
    tok_ep <= ~ep;
    look();
  endtask
  task automatic data(input logic [10:0] n, input logic [1:0] p, input logic crc, dir);
    @(posedge mclk);
    rx_done <= 1'b1;
    rx_len <= n;
    rx_pid <= p;
    rx_crc_err <= crc;
    setup_dir_in <= dir;
    @(posedge mclk);
    rx_done <= 1'b0;
    rx_len <= ~n;
    rx_pid <= ~p;
    rx_crc_err <= ~crc;
    setup_dir_in <= ~dir;
    look();
  endtask
  task automatic ack();
    @(posedge mclk);
    host_ack <= 1'b1;
    @(posedge mclk);
    host_ack <= 1'b0;
  endtask
endmodule // usb_host_model

// ---- tb/tb.sv ----
// self-checking bench for the usb endpoint engine
`include "usb_ep_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, wr, rd, tok_valid, rx_done, rx_crc_err;
  logic        setup_dir_in, host_ack, sof, hs_valid, tx_start;
  logic [3:0]  addr, tok_ep;
  logic [15:0] wdata, rdata;
  logic [1:0]  tok_type, rx_pid, hs_code, tx_pid;
  logic [10:0] rx_len, tx_len, m, r;
  int          errors, compares;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  usb_host_model i_host (.*);
  usb_device_endpoint_engine i_dut (.*);
  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] k,
                        input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata & k);
  endtask
  task automatic hs_chk(input string nm, input logic h, input logic [1:0] c);
    chk(nm, {13'h0, h, h ? c : 2'h0}, {13'h0, i_host.got_hs, h ? i_host.hs_seen : 2'h0});
  endtask
  task automatic tx_chk(input string nm, input logic [10:0] n);
    chk(nm, {5'h1, n}, {4'h0, i_host.got_tx, i_host.len_seen});
  endtask
  task automatic load(input logic [10:0] n);
    repeat (n) wr_reg(`R_TXFIFO, 16'($urandom_range(0, 255)));
  endtask
  task automatic setup(input logic dir);
    i_host.token(`TOK_SETUP, 4'h0);
    i_host.data(11'h008, `PID_D0, 1'b0, dir);
    hs_chk("setup ack", 1'b1, `HS_ACK);
    rd_chk("setup ready", `R_CSR0, 16'h0001, 16'h0001);
    rd_chk("ep0 irq", `R_IRQIN, 16'h0001, 16'h0001);
    wr_reg(`R_CSR0, 16'h0040);
    wr_reg(`R_IRQIN, 16'h0fff);
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    {rst_n, addr, wdata, wr, rd, errors, compares} = '0;
    void'($urandom(41858));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      rd_chk("reset value", 4'(i), 16'hffff, (i == 5 || i == 8) ? 16'h0020 : 16'h0000);
    wr_reg(4'hc, 16'hffff);
    rd_chk("unmapped", 4'hc, 16'hffff, 16'h0000);
    $display("test reset done");
    setup(1'b0);
    wr_reg(`R_CSR0, 16'h0008);
    i_host.token(`TOK_OUT, 4'h0);
    i_host.data(11'h000, `PID_D1, 1'b0, 1'b0);
    hs_chk("write overrun", 1'b1, `HS_STALL);
    rd_chk("ep0 stall flag", `R_CSR0, 16'h0004, 16'h0004);
    rd_chk("ep0 stall irq", `R_IRQIN, 16'h0001, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      wr_reg(`R_CSR0, 16'h0000);
      setup(1'b1);
      wr_reg(`R_CSR0, 16'h040a);
      i_host.token(`TOK_IN, 4'h0);
      tx_chk("ep0 in len", 11'h004);
      i_host.ack();
      i_host.token(k ? `TOK_OUT : `TOK_IN, 4'h0);
      if (k) i_host.data(11'h003, `PID_D1, 1'b0, 1'b0);
      hs_chk("read overrun", 1'b1, `HS_STALL);
    end
    wr_reg(`R_CSR0, 16'h0000);
    setup(1'b1);
    setup(1'b1);
    rd_chk("early end", `R_CSR0, 16'h0010, 16'h0010);
    wr_reg(`R_CSR0, 16'h0080);
    $display("test ep0 done");
    wr_reg(`R_TXMAX, 16'h0040);
    wr_reg(`R_TXCL, 16'h0010);
    i_host.token(`TOK_IN, 4'h1);
    hs_chk("in stall", 1'b1, `HS_STALL);
    rd_chk("in stall flag", `R_TXCL, 16'h0020, 16'h0020);
    rd_chk("in irq", `R_IRQIN, 16'h0002, 16'h0002);
    wr_reg(`R_RXMAX, 16'h0040);
    wr_reg(`R_RXCL, 16'h0020);
    i_host.token(`TOK_OUT, 4'h1);
    i_host.data(11'h00a, `PID_D0, 1'b0, 1'b0);
    hs_chk("out stall", 1'b1, `HS_STALL);
    rd_chk("out stall flag", `R_RXCL, 16'h0040, 16'h0040);
    rd_chk("out irq", `R_IRQOUT, 16'h0002, 16'h0002);
    wr_reg(`R_TXCL, 16'h0040);
    wr_reg(`R_RXCL, 16'h0090);
    $display("test stall done");
    m = 11'($urandom_range(8, 64));
    r = 11'($urandom_range(1, m));
    wr_reg(`R_TXMAX, {3'h0, 2'h1, m});
    load(m + r);
    wr_reg(`R_TXCL, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      i_host.token(`TOK_IN, 4'h1);
      tx_chk("split len", k ? r : m);
      chk("split pid", 16'(k), {14'h0, i_host.pid_seen});
      i_host.ack();
    end
    wr_reg(`R_TXMAX, {5'h0, m});
    wr_reg(`R_TXCH, 16'h00a2);
    load(m);
    rd_chk("autoset", `R_TXCL, 16'h0003, 16'h0003);
    i_host.token(`TOK_IN, 4'h1);
    tx_chk("autoset len", m);
    i_host.ack();
    wr_reg(`R_TXCH, 16'h00a0);
    load(m);
    rd_chk("double one", `R_TXCL, 16'h0003, 16'h0002);
    load(m);
    rd_chk("double two", `R_TXCL, 16'h0003, 16'h0003);
    wr_reg(`R_TXCL, 16'h0048);
    wr_reg(`R_TXCH, 16'h0038);
    repeat (2) load(m);
    repeat (2) wr_reg(`R_TXCL, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      i_host.token(`TOK_IN, 4'h1);
      chk("forced toggle", 16'(k), {14'h0, i_host.pid_seen});
    end
    $display("test in done");
    wr_reg(`R_RXMAX, {5'h0, m});
    wr_reg(`R_RXCH, 16'h0032);
    i_host.token(`TOK_OUT, 4'h1);
    i_host.data(m, `PID_D0, 1'b0, 1'b0);
    hs_chk("int out ack", 1'b1, `HS_ACK);
    i_host.token(`TOK_PING, 4'h1);
    hs_chk("int ping", 1'b0, 2'h0);
    wr_reg(`R_RXCL, 16'h0090);
    wr_reg(`R_RXCH, 16'h00a0);
    i_host.token(`TOK_OUT, 4'h1);
    i_host.data(m, `PID_D0, 1'b0, 1'b0);
    rd_chk("out ready", `R_RXCL, 16'h0001, 16'h0001);
    repeat (m) rd_chk("fifo byte", `R_RXFIFO, 16'h0000, 16'h0000);
    rd_chk("autoclear", `R_RXCL, 16'h0001, 16'h0000);
    $display("test out done");
    wr_reg(`R_TXCH, 16'h0010);
    wr_reg(`R_TXCL, 16'h0008);
    i_host.token(`TOK_IN, 4'h1);
    tx_chk("underrun zlp", 11'h000);
    rd_chk("underrun flag", `R_TXCL, 16'h0004, 16'h0004);
    wr_reg(`R_RXCH, 16'h0012);
    wr_reg(`R_RXCL, 16'h0010);
    i_host.token(`TOK_OUT, 4'h1);
    i_host.data(11'h005, `PID_D0, 1'b1, 1'b0);
    hs_chk("iso quiet", 1'b0, 2'h0);
    rd_chk("crc stored", `R_RXCL, 16'h0009, 16'h0009);
    rd_chk("crc count", `R_RXCNT, 16'h07ff, 16'h0005);
    i_host.token(`TOK_OUT, 4'h1);
    i_host.data(11'h005, `PID_D0, 1'b0, 1'b0);
    rd_chk("overrun", `R_RXCL, 16'h0004, 16'h0004);
    $display("test iso done");
    final_report();
  end
endmodule // tb
